// file: rtl/ou_pkg.sv
package ou_pkg;
  localparam int NCH = 8;
  localparam int FIFO_DEPTH = 64;
  localparam int RX_W = 11;
  localparam logic [7:0] BAR0_CFG_OFFSET = 8'h10;
  localparam int SPACE_BYTES = 4096;
  localparam logic [11:0] CH_STRIDE = 12'h200;
  // offsets inside one channel set
  localparam logic [8:0] OFF_DATA = 9'h000;
  localparam logic [8:0] OFF_IER = 9'h001;
  localparam logic [8:0] OFF_ISR = 9'h002;
  localparam logic [8:0] OFF_LCR = 9'h003;
  localparam logic [8:0] OFF_MCR = 9'h004;
  localparam logic [8:0] OFF_LSR = 9'h005;
  localparam logic [8:0] OFF_MSR = 9'h006;
  localparam logic [8:0] OFF_SPR = 9'h007;
  localparam logic [8:0] OFF_EFR = 9'h009;
  localparam logic [8:0] OFF_CFG_END = 9'h00f;
  localparam logic [8:0] OFF_CHANNEL_IRQ_FLAGS_BYTE0 = 9'h080;
  localparam logic [8:0] OFF_IRQ_SOURCE_DETAIL_BYTE1 = 9'h081;
  localparam logic [8:0] OFF_IRQ_SOURCE_DETAIL_BYTE2 = 9'h082;
  localparam logic [8:0] OFF_IRQ_SOURCE_DETAIL_BYTE3 = 9'h083;
  localparam logic [8:0] OFF_TMR_CTL = 9'h084;
  localparam logic [8:0] OFF_TMR_LO = 9'h086;
  localparam logic [8:0] OFF_TMR_HI = 9'h087;
  localparam logic [8:0] OFF_XMODE = 9'h088;
  localparam logic [8:0] OFF_SRST = 9'h08a;
  localparam logic [8:0] OFF_SLEEP = 9'h08b;
  localparam logic [8:0] OFF_REV = 9'h08c;
  localparam logic [8:0] OFF_PART = 9'h08d;
  localparam logic [8:0] OFF_BCAST = 9'h08e;
  localparam logic [8:0] OFF_AUX_MASK = 9'h08f;
  localparam logic [8:0] OFF_AUX_LVL = 9'h090;
  localparam logic [8:0] OFF_AUX_HIZ = 9'h091;
  localparam logic [8:0] OFF_AUX_INV = 9'h092;
  localparam logic [8:0] OFF_AUX_DIR = 9'h093;
  localparam logic [8:0] OFF_FIFO = 9'h100;
  localparam logic [8:0] OFF_ERRWIN = 9'h180;
  // field positions and values
  localparam int LCR_DLAB_BIT = 7;
  localparam logic [7:0] LCR_DIV_ACCESS = 8'h80;
  localparam int EFR_ENH_BIT = 4;
  localparam logic [7:0] EFR_ENH_SET = 8'h10;
  localparam logic [7:0] EFR_ENH_CLR = 8'h00;
  localparam int MCR_PRESC_BIT = 7;
  localparam int TMR_RUN_BIT = 0;
  localparam int TMR_IE_BIT = 1;
  localparam int TMR_FLAG_BIT = 7;
  localparam int BCAST_BIT = 0;
  localparam logic [7:0] AUX_DIR_RST = 8'hff;
  localparam logic [7:0] ISR_NONE = 8'h01;
  localparam logic [7:0] ISR_TX = 8'h02;
  localparam logic [7:0] ISR_RX = 8'h04;
  localparam logic [15:0] MIN_DIV_SINGLE = 16'h0003;
  // host controller registers (byte offsets)
  localparam logic [4:0] H_TGT_ADDR = 5'h00;
  localparam logic [4:0] H_TGT_DATA = 5'h04;
  localparam logic [4:0] H_CMD = 5'h08;
  localparam logic [4:0] H_RESULT = 5'h0c;
  localparam logic [4:0] H_EVENT = 5'h10;
  localparam logic [4:0] H_MASK = 5'h14;
  localparam logic [4:0] H_STATUS = 5'h18;
  localparam logic [2:0] OP_WRITE = 3'h1;
  localparam logic [2:0] OP_READ = 3'h2;
  localparam logic [2:0] OP_DIV = 3'h3;
  localparam logic [2:0] OP_PRESC = 3'h4;
  localparam int EV_DONE = 0;
  localparam int EV_REFUSED = 1;
  localparam int EV_DEV_IRQ = 2;
endpackage : ou_pkg

// file: rtl/ou_bus_if.sv
interface ou_bus_if;
  logic [11:2] addr;
  logic [3:0] be;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic irq;
  modport dev (input addr, be, wdata, wr, rd, output rdata, irq);
  modport host (output addr, be, wdata, wr, rd, input rdata, irq);
endinterface : ou_bus_if

// file: rtl/ou_fifo.sv
module ou_fifo #(
  parameter int W = 8,
  parameter int D = 64
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(D);

  if (D < 2 || (D & (D - 1)) != 0) begin : g_chk
    $error("fifo depth must be a power of two");
  end

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } ou_fifo_s;

  ou_fifo_s q, d;
  logic full;

  always_comb begin
    full = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
    in_ready_o = !full;
    out_valid_o = (q.wp != q.rp);
    out_data_o = q.mem[q.rp[AW-1:0]];
    d = q;
    if (flush_i) begin
      d.wp = '0;
      d.rp = '0;
    end else begin
      if (in_valid_i && !full) begin
        d.mem[q.wp[AW-1:0]] = in_data_i;
        d.wp = q.wp + 1'b1;
      end
      if (out_ready_i && out_valid_o) begin
        d.rp = q.rp + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : ou_fifo

// file: rtl/ou_device.sv
// How it works
// RL1: whole space is one 4K memory window
// RL2: byte, half and word accesses; error window half and word only
// RL3: host reads error window 16/32 bits wide
// RL4: eight channel sets, 0x200 apart
// RL5: config registers 0x000-0x00F, classic layout
// RL6: device registers only in channel 0
// RL7: offset 0x100 pops rx, pushes tx
// RL8: error window pairs byte with status
// RL9: 16-bit timer, control and split value
// RL10: write-only reset, read-write sleep register
// RL11: write-only broadcast and prom control
// RL12: aux pin mask, level, hiz, polarity, direction
// RL13: address is base plus set plus offset
// RL14: divisor change via line control 0x80
// RL15: modem bits 5-7 gated by enhanced bit
// RL16: prescaler change brackets with enhanced bit
// RL17: single-ended divisor below 3 only with prescaler on
// RL18: reserved offsets read zero, ignore writes
module ou_device #(
  parameter logic [7:0] REV_ID = 8'h5a,  // arbitrary value
  parameter logic [7:0] PART_ID = 8'ha5  // arbitrary value
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // register bus
  ou_bus_if.dev bus,
  // transmit streams
  output logic [ou_pkg::NCH-1:0] tx_valid_o,
  output logic [ou_pkg::NCH-1:0][7:0] tx_data_o,
  input wire logic [ou_pkg::NCH-1:0] tx_ready_i,
  // receive streams, error bits are break, framing, parity
  input wire logic [ou_pkg::NCH-1:0] rx_valid_i,
  input wire logic [ou_pkg::NCH-1:0][7:0] rx_data_i,
  input wire logic [ou_pkg::NCH-1:0][2:0] rx_err_i,
  output logic [ou_pkg::NCH-1:0] rx_ready_o,
  // line settings for the framers
  output logic [ou_pkg::NCH-1:0][15:0] divisor_o,
  output logic [ou_pkg::NCH-1:0][7:0] line_ctl_o,
  output logic [ou_pkg::NCH-1:0] presc_o,
  output logic [7:0] sample_rate_o,
  output logic [7:0] sleep_o,
  output logic [7:0] prom_ctl_o,
  // aux pins
  input wire logic [7:0] aux_pin_i,
  output logic [7:0] aux_pin_o,
  output logic [7:0] aux_pin_oe_o
);
  import ou_pkg::*;

  typedef struct packed {
    logic [NCH-1:0][7:0] line_control_register;
    logic [NCH-1:0][7:0] ier;
    logic [NCH-1:0][7:0] modem_control_register;
    logic [NCH-1:0][7:0] enhanced_feature_register;
    logic [NCH-1:0][7:0] spr;
    logic [NCH-1:0][7:0] dll;
    logic [NCH-1:0][7:0] divisor_high_byte;
    logic [NCH-1:0] ovr;
    logic [7:0] tmr_ctl;
    logic [15:0] tmr_val;
    logic [15:0] tmr_cnt;
    logic tmr_flag;
    logic [7:0] xmode;
    logic [7:0] sleep;
    logic [7:0] bcast;
    logic [7:0] aux_mask;
    logic [7:0] aux_lvl;
    logic [7:0] aux_hiz;
    logic [7:0] aux_inv;
    logic [7:0] aux_dir;
    logic [31:0] rdata;
    logic irq;
  } ou_dev_s;

  ou_dev_s q, d;
  logic [NCH-1:0] rx_pop, tx_push, flush, rx_v, tx_in_rdy, tx_empty, pend;
  logic [NCH-1:0][RX_W-1:0] rx_head;
  logic [2:0] ch;
  logic [8:0] off;
  logic [7:0] wb, rb, aux_in;
  logic [NCH-1:0] tgt;
  logic [23:0] src;

  function automatic logic [7:0] lsr_of(input logic dr, input logic ovr,
      input logic [2:0] err, input logic thre);
    lsr_of = {1'b0, thre, thre, err & {3{dr}}, ovr, dr};
  endfunction : lsr_of

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    ou_fifo #(.W(8), .D(FIFO_DEPTH)) u_tx (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .flush_i(flush[c]),
      .in_valid_i(tx_push[c]), .in_data_i(bus.wdata[7:0]),
      .in_ready_o(tx_in_rdy[c]), .out_valid_o(tx_valid_o[c]),
      .out_data_o(tx_data_o[c]), .out_ready_i(tx_ready_i[c]));
    ou_fifo #(.W(RX_W), .D(FIFO_DEPTH)) u_rx (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .flush_i(flush[c]),
      .in_valid_i(rx_valid_i[c]), .in_data_i({rx_err_i[c], rx_data_i[c]}),
      .in_ready_o(rx_ready_o[c]), .out_valid_o(rx_v[c]),
      .out_data_o(rx_head[c]), .out_ready_i(rx_pop[c]));
    assign tx_empty[c] = !tx_valid_o[c];
    assign pend[c] = (q.ier[c][0] && rx_v[c]) || (q.ier[c][1] && tx_empty[c]);
    assign src[3*c +: 3] = rx_v[c] && q.ier[c][0] ? 3'h1 :
                           (tx_empty[c] && q.ier[c][1] ? 3'h2 : 3'h0);
    assign divisor_o[c] = {q.divisor_high_byte[c], q.dll[c]};
  end

  always_comb begin
    d = q;
    rx_pop = '0;
    tx_push = '0;
    flush = '0;
    rb = 8'h00;
    wb = 8'h00;
    off = 9'h000;
    ch = bus.addr[11:9];  // RL4 RL13
    aux_in = aux_pin_i ^ q.aux_inv;
    for (int c = 0; c < NCH; c++) begin
      // broadcast mirrors channel 0 config writes into every channel
      tgt[c] = (3'(c) == ch) || (q.bcast[BCAST_BIT] && ch == 3'h0 &&
               bus.addr[8:4] == 5'h00);  // RL11
    end
    for (int l = 0; l < 4; l++) begin
      off = {bus.addr[8:2], 2'(l)};  // RL1 RL2
      wb = bus.wdata[8*l +: 8];
      rb = 8'h00;
      if (!bus.be[l]) begin
        rb = 8'h00;
      end else if (off == OFF_DATA) begin  // RL5
        rb = q.line_control_register[ch][LCR_DLAB_BIT] ? q.dll[ch] : rx_head[ch][7:0];
        rx_pop[ch] = bus.rd && !q.line_control_register[ch][LCR_DLAB_BIT];
      end else if (off == OFF_IER) begin
        rb = q.line_control_register[ch][LCR_DLAB_BIT] ? q.divisor_high_byte[ch] : q.ier[ch];
      end else if (off == OFF_ISR) begin
        rb = rx_v[ch] && q.ier[ch][0] ? ISR_RX :
             (tx_empty[ch] && q.ier[ch][1] ? ISR_TX : ISR_NONE);
      end else if (off == OFF_LCR) begin
        rb = q.line_control_register[ch];
      end else if (off == OFF_MCR) begin
        rb = q.modem_control_register[ch];
      end else if (off == OFF_LSR) begin
        rb = lsr_of(rx_v[ch], q.ovr[ch], rx_head[ch][10:8], tx_empty[ch]);
        if (bus.rd) d.ovr[ch] = 1'b0;
      end else if (off == OFF_SPR) begin
        rb = q.spr[ch];
      end else if (off == OFF_EFR) begin
        rb = q.enhanced_feature_register[ch];
      end else if (off == OFF_FIFO && l == 0) begin  // RL7
        rb = rx_head[ch][7:0];
        rx_pop[ch] = bus.rd;
      end else if (off >= OFF_ERRWIN && bus.be[1:0] == 2'b11) begin  // RL8
        if (l == 0) begin
          rb = rx_head[ch][7:0];
          rx_pop[ch] = bus.rd;
        end else if (l == 1) begin
          rb = lsr_of(rx_v[ch], q.ovr[ch], rx_head[ch][10:8], tx_empty[ch]);
        end
      end else if (ch != 3'h0) begin
        rb = 8'h00;  // RL6 RL18
      end else if (off >= OFF_CHANNEL_IRQ_FLAGS_BYTE0 && off <= OFF_IRQ_SOURCE_DETAIL_BYTE3) begin
        rb = off == OFF_CHANNEL_IRQ_FLAGS_BYTE0 ? pend : src[8*(off[1:0]-2'd1) +: 8];
      end else if (off == OFF_TMR_CTL) begin  // RL9
        rb = {q.tmr_flag, q.tmr_ctl[6:0]};
        if (bus.rd) d.tmr_flag = 1'b0;
      end else if (off == OFF_TMR_LO) begin
        rb = q.tmr_val[7:0];
      end else if (off == OFF_TMR_HI) begin
        rb = q.tmr_val[15:8];
      end else if (off == OFF_XMODE) begin
        rb = q.xmode;
      end else if (off == OFF_SLEEP) begin  // RL10
        rb = q.sleep;
      end else if (off == OFF_REV) begin
        rb = REV_ID;
      end else if (off == OFF_PART) begin
        rb = PART_ID;
      end else if (off == OFF_AUX_MASK) begin  // RL12
        rb = q.aux_mask;
      end else if (off == OFF_AUX_LVL) begin
        rb = (aux_in & q.aux_dir) | (q.aux_lvl & ~q.aux_dir);
      end else if (off == OFF_AUX_HIZ) begin
        rb = q.aux_hiz;
      end else if (off == OFF_AUX_INV) begin
        rb = q.aux_inv;
      end else if (off == OFF_AUX_DIR) begin
        rb = q.aux_dir;
      end
      d.rdata[8*l +: 8] = bus.rd ? rb : 8'h00;
      if (bus.wr && bus.be[l]) begin
        for (int c = 0; c < NCH; c++) begin
          if (!tgt[c]) begin
            d.spr[c] = d.spr[c];
          end else if (off == OFF_DATA) begin
            if (q.line_control_register[c][LCR_DLAB_BIT]) d.dll[c] = wb;  // RL14
            else tx_push[c] = 1'b1;
          end else if (off == OFF_IER) begin
            if (q.line_control_register[c][LCR_DLAB_BIT]) d.divisor_high_byte[c] = wb;
            else d.ier[c] = wb;
          end else if (off == OFF_LCR) begin
            d.line_control_register[c] = wb;
          end else if (off == OFF_MCR) begin
            d.modem_control_register[c][4:0] = wb[4:0];
            if (q.enhanced_feature_register[c][EFR_ENH_BIT]) d.modem_control_register[c][7:5] = wb[7:5];  // RL15
          end else if (off == OFF_SPR) begin
            d.spr[c] = wb;
          end else if (off == OFF_EFR) begin
            d.enhanced_feature_register[c] = wb;
          end else if (off == OFF_FIFO && l == 0) begin
            tx_push[c] = 1'b1;  // RL7
          end
        end
        if (ch != 3'h0) begin
          d.irq = q.irq;  // RL18
        end else if (off == OFF_TMR_CTL) begin
          d.tmr_ctl = wb;
        end else if (off == OFF_TMR_LO) begin
          d.tmr_val[7:0] = wb;
        end else if (off == OFF_TMR_HI) begin
          d.tmr_val[15:8] = wb;
        end else if (off == OFF_XMODE) begin
          d.xmode = wb;
        end else if (off == OFF_SRST) begin  // RL10
          for (int c = 0; c < NCH; c++) begin
            if (wb[c]) begin
              flush[c] = 1'b1;
              d.line_control_register[c] = '0;
              d.ier[c] = '0;
              d.modem_control_register[c] = '0;
              d.enhanced_feature_register[c] = '0;
              d.ovr[c] = 1'b0;
            end
          end
        end else if (off == OFF_SLEEP) begin
          d.sleep = wb;
        end else if (off == OFF_BCAST) begin
          d.bcast = wb;  // RL11
        end else if (off == OFF_AUX_MASK) begin
          d.aux_mask = wb;
        end else if (off == OFF_AUX_LVL) begin
          d.aux_lvl = wb;
        end else if (off == OFF_AUX_HIZ) begin
          d.aux_hiz = wb;
        end else if (off == OFF_AUX_INV) begin
          d.aux_inv = wb;
        end else if (off == OFF_AUX_DIR) begin
          d.aux_dir = wb;
        end
      end
    end
    // a push into a full fifo is lost: overrun, set beats the read clear
    for (int c = 0; c < NCH; c++) begin
      if (rx_valid_i[c] && !rx_ready_o[c]) d.ovr[c] = 1'b1;
      if (!tx_in_rdy[c]) tx_push[c] = 1'b0;
    end
    // RL9: down counter reloads from the programmed value
    if (!q.tmr_ctl[TMR_RUN_BIT] || q.tmr_cnt == 16'h0000) begin
      d.tmr_cnt = q.tmr_val;
    end else begin
      d.tmr_cnt = q.tmr_cnt - 16'h0001;
      if (q.tmr_cnt == 16'h0001) d.tmr_flag = 1'b1;
    end
    d.irq = (|pend) || (q.tmr_flag && q.tmr_ctl[TMR_IE_BIT]) ||
            (|(aux_in & q.aux_mask & q.aux_dir));
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.aux_dir <= AUX_DIR_RST;
    end else begin
      q <= d;
    end
  end

  assign bus.rdata = q.rdata;
  assign bus.irq = q.irq;
  assign line_ctl_o = q.line_control_register;
  for (genvar c = 0; c < NCH; c++) begin : g_presc
    assign presc_o[c] = q.modem_control_register[c][MCR_PRESC_BIT];
  end
  assign sample_rate_o = q.xmode;
  assign sleep_o = q.sleep;
  assign prom_ctl_o = q.bcast;
  assign aux_pin_o = q.aux_lvl;
  assign aux_pin_oe_o = ~q.aux_dir & ~q.aux_hiz;  // RL12
endmodule : ou_device

// file: rtl/ou_host.sv
module ou_host #(
  parameter logic [7:0] SINGLE_ENDED = 8'hff
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // software port
  input wire logic [4:0] sw_addr_i,
  input wire logic [31:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [31:0] sw_rdata_o,
  output logic irq_o,
  // device bus
  ou_bus_if.host bus
);
  import ou_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ISSUE = 3'b010,
    ST_WAIT = 3'b100
  } ou_hst_e;

  typedef struct packed {
    ou_hst_e st;
    logic [11:0] tgt;
    logic [31:0] data;
    logic [3:0] be;
    logic [2:0] op;
    logic [1:0] step;
    logic [31:0] result;
    logic [2:0] evt;
    logic [2:0] mask;
    logic [7:0] presc;
    logic dirq;
    logic [11:2] addr;
    logic [3:0] bbe;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] sw_rdata;
  } ou_hst_s;

  ou_hst_s q, d;
  logic [45:0] nxt;
  logic last, bad;
  logic [2:0] nop;

  // one byte write to a channel register, placed in its own lane
  // 46 bits: a narrower word drops the top channel bit and aliases sets 4-7
  function automatic logic [45:0] put(input logic [2:0] c,
      input logic [8:0] o, input logic [7:0] b);
    put = {c, o[8:2], 4'(1 << o[1:0]), 32'(b) << (8 * o[1:0])};
  endfunction : put

  // steps of each ordered sequence: addr, byte enables, data
  function automatic logic [45:0] step_of(input logic [2:0] op,
      input logic [1:0] s, input logic [11:0] t, input logic [3:0] be,
      input logic [31:0] dt);
    step_of = {t[11:2], be, dt};
    if (op == OP_DIV) begin  // RL14
      case (s)
        2'd0: step_of = put(t[11:9], OFF_LCR, LCR_DIV_ACCESS);
        2'd1: step_of = put(t[11:9], OFF_DATA, dt[7:0]);
        2'd2: step_of = put(t[11:9], OFF_IER, dt[15:8]);
        default: step_of = put(t[11:9], OFF_LCR, dt[23:16]);
      endcase
    end else if (op == OP_PRESC) begin  // RL16
      case (s)
        2'd0: step_of = put(t[11:9], OFF_EFR, EFR_ENH_SET);
        2'd1: step_of = put(t[11:9], OFF_MCR, dt[7:0]);
        default: step_of = put(t[11:9], OFF_EFR, EFR_ENH_CLR);
      endcase
    end
  endfunction : step_of

  always_comb begin
    d = q;
    nop = sw_wdata_i[6:4];
    last = (q.op == OP_DIV) ? (q.step == 2'd3) :
           (q.op == OP_PRESC) ? (q.step == 2'd2) : 1'b1;
    // RL3 RL17: refuse unpaired error reads and too small divisors
    bad = (nop == OP_READ && q.tgt[8:0] >= OFF_ERRWIN &&
           sw_wdata_i[1:0] != 2'b11) ||
          (nop == OP_DIV && q.data[15:0] < MIN_DIV_SINGLE &&
           SINGLE_ENDED[q.tgt[11:9]] && !q.presc[q.tgt[11:9]]) ||
          nop == 3'h0 || nop > OP_PRESC;
    nxt = step_of(q.op, q.step + 2'd1, q.tgt, q.be, q.data);
    d.wr = 1'b0;
    d.rd = 1'b0;
    d.sw_rdata = '0;
    if (sw_rd_i) begin
      if (sw_addr_i == H_TGT_ADDR) d.sw_rdata = 32'(q.tgt);
      else if (sw_addr_i == H_TGT_DATA) d.sw_rdata = q.data;
      else if (sw_addr_i == H_CMD) d.sw_rdata = 32'(q.st != ST_IDLE);
      else if (sw_addr_i == H_RESULT) d.sw_rdata = q.result;
      else if (sw_addr_i == H_EVENT) d.sw_rdata = 32'(q.evt);
      else if (sw_addr_i == H_MASK) d.sw_rdata = 32'(q.mask);
      else if (sw_addr_i == H_STATUS)
        d.sw_rdata = {16'h0000, q.presc, 6'h00, q.dirq, q.st != ST_IDLE};
      if (sw_addr_i == H_EVENT) d.evt = '0;
    end
    if (sw_wr_i) begin
      if (sw_addr_i == H_TGT_ADDR) d.tgt = sw_wdata_i[11:0];
      else if (sw_addr_i == H_TGT_DATA) d.data = sw_wdata_i;
      else if (sw_addr_i == H_MASK) d.mask = sw_wdata_i[2:0];
    end
    case (q.st)
      ST_IDLE: begin
        if (sw_wr_i && sw_addr_i == H_CMD) begin
          if (bad) begin
            d.evt[EV_REFUSED] = 1'b1;
          end else begin
            d.op = nop;
            d.be = sw_wdata_i[3:0];
            d.step = 2'd0;
            {d.addr, d.bbe, d.wdata} =
              step_of(nop, 2'd0, q.tgt, sw_wdata_i[3:0], q.data);
            d.rd = (nop == OP_READ);
            d.wr = !d.rd;
            if (nop == OP_PRESC) d.presc[q.tgt[11:9]] = q.data[MCR_PRESC_BIT];
            d.st = ST_ISSUE;
          end
        end
      end
      ST_ISSUE: begin
        d.st = ST_WAIT;
      end
      ST_WAIT: begin
        if (q.op == OP_READ) d.result = bus.rdata;
        if (last) begin
          d.evt[EV_DONE] = 1'b1;
          d.st = ST_IDLE;
        end else begin
          d.step = q.step + 2'd1;
          {d.addr, d.bbe, d.wdata} = nxt;
          d.wr = 1'b1;
          d.st = ST_ISSUE;
        end
      end
      default: d.st = ST_IDLE;
    endcase
    if (sw_wr_i && sw_addr_i == H_CMD && q.st != ST_IDLE) begin
      d.evt[EV_REFUSED] = 1'b1;
    end
    d.dirq = bus.irq;
    if (bus.irq && !q.dirq) d.evt[EV_DEV_IRQ] = 1'b1;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.st <= ST_IDLE;
    end else begin
      q <= d;
    end
  end

  assign bus.addr = q.addr;
  assign bus.be = q.bbe;
  assign bus.wdata = q.wdata;
  assign bus.wr = q.wr;
  assign bus.rd = q.rd;
  assign sw_rdata_o = q.sw_rdata;
  assign irq_o = |(q.evt & q.mask);
endmodule : ou_host

// file: test/ou_bus_checker.sv
module ou_bus_checker (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // bus signals
  input wire logic [11:2] addr,
  input wire logic [3:0] be,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  one_strobe_a: assert property (!(wr && rd))
    else $error("strobes together");
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 0)
    else $error("read data outside answer cycle");
  rsvd_gap_a: assert property (rd && addr[8:2] inside
    {[7'h04:7'h1f], [7'h25:7'h3f], [7'h41:7'h5f]} |=> rdata == 0)
    else $error("reserved offset not zero");
  ch_devregs_a: assert property (rd && addr[11:9] != 0 &&
    addr[8:2] inside {[7'h20:7'h24]} |=> rdata == 0)
    else $error("device registers seen outside channel 0");
  errwin_width_a: assert property (rd && addr[8:7] == 2'b11
    |-> be[1:0] == 2'b11) else $error("narrow read of paired window");
  errwin_pair_a: assert property (rd && addr[8:7] == 2'b11
    |=> rdata[31:16] == 0) else $error("paired read upper lanes set");
  fifo_byte_a: assert property (rd && addr[8:2] == 7'h40
    |=> rdata[31:8] == 0) else $error("fifo window upper lanes set");
  wo_reset_a: assert property (rd && addr == 10'h022
    |=> rdata[23:16] == 0) else $error("write-only reset readable");
  wo_bcast_a: assert property (rd && addr == 10'h023
    |=> rdata[23:16] == 0) else $error("write-only broadcast readable");
  rsvd_timer_a: assert property (rd && addr == 10'h021
    |=> rdata[15:8] == 0) else $error("reserved timer byte not zero");
endmodule : ou_bus_checker

// file: test/octal_uart_pci_register_map_tb.sv
module octal_uart_pci_register_map_tb;
  import ou_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 0, rst_i = 1, sw_wr_i = 0, sw_rd_i = 0, irq_o;
  logic [4:0] sw_addr_i = '0;
  logic [31:0] sw_wdata_i = '0, sw_rdata_o, d;
  logic [NCH-1:0] tx_valid_o, tx_ready_i = '0, rx_valid_i = '0;
  logic [NCH-1:0] rx_ready_o, presc_o;
  logic [NCH-1:0][7:0] tx_data_o, rx_data_i = '0, line_ctl_o;
  logic [NCH-1:0][2:0] rx_err_i = '0;
  logic [NCH-1:0][15:0] divisor_o;
  logic [7:0] sample_rate_o, sleep_o, prom_ctl_o, aux_pin_o, aux_pin_oe_o;
  logic [7:0] aux_pin_i = 8'h00;
  int err_total = 0, n_compared = 0;
  ou_bus_if bus_if ();
  ou_host i_ou_host (.sys_clk_i, .rst_i, .sw_addr_i, .sw_wdata_i,
    .sw_wr_i, .sw_rd_i, .sw_rdata_o, .irq_o, .bus(bus_if));
  // identity values are arbitrary
  ou_device #(.REV_ID(8'h3c), .PART_ID(8'hc3)) i_ou_device (.sys_clk_i,
    .rst_i, .bus(bus_if), .tx_valid_o, .tx_data_o, .tx_ready_i,
    .rx_valid_i, .rx_data_i, .rx_err_i, .rx_ready_o, .divisor_o,
    .line_ctl_o, .presc_o, .sample_rate_o, .sleep_o, .prom_ctl_o,
    .aux_pin_i, .aux_pin_o, .aux_pin_oe_o);
  ou_bus_checker i_ou_bus_checker (.sys_clk_i, .rst_i,
    .addr(bus_if.addr), .be(bus_if.be), .wdata(bus_if.wdata),
    .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata),
    .irq(bus_if.irq));
  task automatic close_out(input bit hang);
    if (hang) err_total++;
    $display("compares %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one software access; read data lands in d
  task automatic sw(input logic [4:0] a, input logic [31:0] v, input bit w);
    @(posedge sys_clk_i);
    sw_addr_i <= a;
    sw_wdata_i <= v;
    sw_wr_i <= w;
    sw_rd_i <= !w;
    @(posedge sys_clk_i);
    sw_wr_i <= 0;
    sw_rd_i <= 0;
    #1 d = sw_rdata_o;
  endtask : sw
  // one host command, polled under a bound; result lands in d
  task automatic op(input logic [2:0] c, input logic [11:0] t,
      input logic [3:0] b, input logic [31:0] v);
    sw(H_TGT_ADDR, {20'h0, t}, 1);
    sw(H_TGT_DATA, v, 1);
    sw(H_CMD, {25'h0, c, b}, 1);
    for (int i = 0; i < 40; i++) begin
      sw(H_CMD, 0, 0);
      if (d[0] === 1'b0) begin
        sw(H_RESULT, 0, 0);
        return;
      end
    end
    close_out(1);
  endtask : op
  initial begin
    forever #50 sys_clk_i = !sys_clk_i;
  end
  initial begin
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 0;
    op(OP_READ, 12'h08c, 4'hf, 0);
    chk(d, 32'h0000c33c);
    op(OP_READ, 12'h090, 4'hf, 0);
    chk(d, 32'hff000000);
    op(OP_WRITE, 12'h088, 4'hf, 32'h11223344);
    op(OP_READ, 12'h088, 4'hf, 0);
    chk(d, 32'h11000044);
    chk({16'h0, sleep_o, sample_rate_o}, 32'h1144);
    op(OP_WRITE, 12'h084, 4'hc, 32'h12340000);
    op(OP_READ, 12'h084, 4'hf, 0);
    chk(d, 32'h12340000);
    // channel 0 first, so later writes must not disturb it
    for (int c = 0; c < NCH; c++) begin
      op(OP_WRITE, 12'(c * 512 + 4), 4'h8, {8'(8'h30 + c), 24'h0});
      op(OP_WRITE, 12'(c * 512 + 'h88), 4'h1, 32'h77);
    end
    for (int c = 0; c < NCH; c++) begin
      op(OP_READ, 12'(c * 512 + 4), 4'h8, 0);
      chk(d, {8'(8'h30 + c), 24'h0});
      op(OP_READ, 12'(c * 512 + 'h88), 4'h1, 0);
      chk(d, (c == 0) ? 32'h77 : 32'h0);
    end
    chk({24'h0, sample_rate_o}, 32'h77);
    op(OP_WRITE, 12'h010, 4'hf, 32'hffffffff);
    op(OP_READ, 12'h010, 4'hf, 0);
    chk(d, 0);
    sw(H_MASK, 32'h2, 1);
    sw(H_EVENT, 0, 0);
    op(OP_READ, 12'h180, 4'h1, 0);
    chk({31'h0, irq_o}, 1);
    sw(H_EVENT, 0, 0);
    chk({31'h0, d[1]}, 1);
    chk({31'h0, irq_o}, 0);
    op(OP_DIV, 12'h400, 4'h0, 32'h00030010);
    chk({line_ctl_o[2], divisor_o[2]}, 32'h030010);
    sw(H_EVENT, 0, 0);
    op(OP_DIV, 12'h400, 4'h0, 32'h00030002);
    sw(H_EVENT, 0, 0);
    chk({d[1], divisor_o[2]}, 32'h10010);
    op(OP_PRESC, 12'h200, 4'h0, 32'h80);
    chk({31'h0, presc_o[1]}, 1);
    op(OP_WRITE, 12'h204, 4'h1, 32'h0);
    chk({31'h0, presc_o[1]}, 1);
    op(OP_DIV, 12'h200, 4'h0, 32'h00030002);
    chk({16'h0, divisor_o[1]}, 32'h2);
    // second byte arrives back to back with the first
    rx_valid_i[0] <= 1;
    rx_data_i[0] <= 8'h5c;
    rx_err_i[0] <= 3'b010;
    @(posedge sys_clk_i);
    rx_data_i[0] <= 8'ha7;
    rx_err_i[0] <= 0;
    @(posedge sys_clk_i);
    rx_valid_i[0] <= 0;
    op(OP_READ, 12'h180, 4'h3, 0);
    chk(d, 32'h0000695c);
    op(OP_READ, 12'h100, 4'hf, 0);
    chk(d, 32'h000000a7);
    op(OP_WRITE, 12'h100, 4'h1, 32'hc4);
    chk({23'h0, tx_valid_o[0], tx_data_o[0]}, 32'h1c4);
    tx_ready_i <= '1;
    @(posedge sys_clk_i);
    #1 chk({31'h0, tx_valid_o[0]}, 0);
    op(OP_WRITE, 12'h090, 4'hf, 32'hf000030f);
    chk({16'h0, aux_pin_oe_o, aux_pin_o}, 32'h0c0f);
    aux_pin_i <= 8'hf0;
    op(OP_READ, 12'h090, 4'hf, 0);
    chk(d, 32'hf00003ff);
    close_out(0);
  end
endmodule : octal_uart_pci_register_map_tb
